// *** hw/vrd_pkg.sv ***
// constants and carrier types of the voice rom and dac control block
`default_nettype none
package vrd_pkg;
    // data memory addresses
    localparam logic [7:0] ADDR_PTR0_HI = 8'h18;
    localparam logic [7:0] ADDR_PTR0_MID = 8'h19;
    localparam logic [7:0] ADDR_PTR0_LO = 8'h1A;
    localparam logic [7:0] ADDR_PTR1_HI = 8'h1B;
    localparam logic [7:0] ADDR_PTR1_MID = 8'h1C;
    localparam logic [7:0] ADDR_PTR1_LO = 8'h1D;
    localparam logic [7:0] ADDR_SPEECH_CTRL = 8'h26;
    localparam logic [7:0] ADDR_DAC_LOW = 8'h27;
    localparam logic [7:0] ADDR_DAC_HIGH = 8'h28;
    localparam logic [7:0] ADDR_LOUDNESS = 8'h29;
    localparam logic [7:0] ADDR_SAMPLE_PORT = 8'h2A;
    // speech_ctrl field positions
    localparam int CTRL_DAC_EN_BIT = 1;
    localparam int CTRL_ROM_EN_BIT = 2;
    localparam int CTRL_PTR_SEL_BIT = 4;
    localparam int CTRL_XTAL_SLOW_BIT = 7;
    localparam logic [7:0] CTRL_USED_MASK = 8'h96;
    localparam logic [7:0] HI_NIBBLE_MASK = 8'hF0;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // rom fetch time
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int FETCH_TIME_NS = 4000;
    localparam int FETCH_CYCLES = (FETCH_TIME_NS * (CLK_FREQ_HZ / 1_000_000)
                                   + 999) / 1000;
    localparam logic [7:0] FETCH_COUNT = 8'(FETCH_CYCLES - 1);
    // processor side access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vrd_req_t;
    // rom side fetch request
    typedef struct packed {
        logic req;
        logic [23:0] addr;
    } vrd_rom_req_t;
    typedef enum logic [1:0] {
        VRD_IDLE = 2'b00,
        VRD_WAIT = 2'b01,
        VRD_DONE = 2'b10
    } vrd_fetch_st_t;
endpackage
`default_nettype wire

// *** hw/vrd_voice_dac_ctrl.sv ***
// register block for the voice rom pointers, dac sample and volume
// Overview of operation
// - dac sample from dac_low high nibble, dac_high
// - dac_low low nibble reads zero
// - eight volume levels from loudness_reg upper nibble
// - loudness_reg low nibble reads zero
// - speech_ctrl bit 1 switches converter
// - converter off gives no valid output
// - converter enable changes only by software
// - bit 2 enables rom, else inaccessible
// - bit 4 selects pointer 0 or 1
// - bit 7 crystal start mode, resets zero
// - bits 0,3,5,6 read zero
// - selected pointer forms 24-bit byte address
// - fetch within 4 us of address write
// - fetched byte read at sample_byte_port
// - pointer bytes at 18H-1AH and 1BH-1DH
// - crystal start mode feeds timer_three clock
`default_nettype none
module vrd_voice_dac_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire vrd_pkg::vrd_req_t i_req,
    input wire logic i_sleep,
    input wire logic [7:0] i_rom_data,
    input wire logic i_rom_ack,
    output logic [7:0] o_rdata,
    output logic [11:0] o_dac_sample,
    output logic [2:0] o_dac_volume,
    output logic o_dac_valid,
    output vrd_pkg::vrd_rom_req_t o_rom,
    output logic o_rom_enable,
    output logic o_xtal_slow_start,
    output logic o_fetch_busy
);
    logic [7:0] ctrl_r;
    logic [7:0] ptr_r [0:5];
    logic [3:0] dac_low_r;
    logic [7:0] dac_high_r;
    logic [3:0] loud_r;
    logic [7:0] rom_byte_r;
    logic [7:0] wait_r;
    logic [7:0] rdata_nxt;
    logic ptr_sel;
    logic ptr_write;
    logic fetch_restart;
    logic [23:0] cur_addr;
    vrd_pkg::vrd_fetch_st_t st_r;

    assign ptr_sel = ctrl_r[vrd_pkg::CTRL_PTR_SEL_BIT];
    // high, middle, low in address order
    assign cur_addr = ptr_sel ? {ptr_r[3], ptr_r[4], ptr_r[5]}
                              : {ptr_r[0], ptr_r[1], ptr_r[2]};
    assign ptr_write = i_req.wr && i_req.addr >= vrd_pkg::ADDR_PTR0_HI
                       && i_req.addr <= vrd_pkg::ADDR_PTR1_LO;
    // any pointer byte or control write starts the fetch over
    assign fetch_restart = ptr_write || (i_req.wr
                           && i_req.addr == vrd_pkg::ADDR_SPEECH_CTRL);

    // sleep input is deliberately ignored here
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctrl_r <= vrd_pkg::CTRL_RESET;
        end else if (i_req.wr && i_req.addr == vrd_pkg::ADDR_SPEECH_CTRL) begin
            ctrl_r <= i_req.wdata & vrd_pkg::CTRL_USED_MASK;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int i = 0; i < 6; i++) begin
                ptr_r[i] <= vrd_pkg::BYTE_RESET;
            end
        end else if (ptr_write) begin
            ptr_r[3'(i_req.addr - vrd_pkg::ADDR_PTR0_HI)] <=
                i_req.wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            dac_low_r <= 4'h0;
            dac_high_r <= vrd_pkg::BYTE_RESET;
            loud_r <= 4'h0;
        end else if (i_req.wr) begin
            if (i_req.addr == vrd_pkg::ADDR_DAC_LOW) begin
                dac_low_r <= i_req.wdata[7:4];
            end
            if (i_req.addr == vrd_pkg::ADDR_DAC_HIGH) begin
                dac_high_r <= i_req.wdata;
            end
            if (i_req.addr == vrd_pkg::ADDR_LOUDNESS) begin
                loud_r <= i_req.wdata[7:4];
            end
        end
    end

    // converter outputs hold until a new write
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_dac_sample <= 12'h000;
            o_dac_volume <= 3'h0;
            o_dac_valid <= 1'b0;
        end else begin
            o_dac_valid <= ctrl_r[vrd_pkg::CTRL_DAC_EN_BIT];
            o_dac_sample <= ctrl_r[vrd_pkg::CTRL_DAC_EN_BIT]
                            ? {dac_high_r, dac_low_r} : 12'h000;
            // eight levels: upper three bits of the written nibble
            o_dac_volume <= loud_r[3:1];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rom_enable <= 1'b0;
            o_xtal_slow_start <= 1'b0;
        end else begin
            o_rom_enable <= ctrl_r[vrd_pkg::CTRL_ROM_EN_BIT];
            o_xtal_slow_start <= ctrl_r[vrd_pkg::CTRL_XTAL_SLOW_BIT];
        end
    end

    // fetch: request rom, latch byte; result stands after FETCH_CYCLES max
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_r <= vrd_pkg::VRD_IDLE;
            wait_r <= 8'h00;
            rom_byte_r <= vrd_pkg::BYTE_RESET;
            o_rom <= '0;
            o_fetch_busy <= 1'b0;
        end else if (fetch_restart) begin
            st_r <= vrd_pkg::VRD_WAIT;
            wait_r <= vrd_pkg::FETCH_COUNT;
            o_rom.req <= 1'b0;
            o_fetch_busy <= 1'b1;
        end else begin
            unique case (st_r)
                vrd_pkg::VRD_IDLE: begin
                    o_rom.req <= 1'b0;
                    o_fetch_busy <= 1'b0;
                end
                vrd_pkg::VRD_WAIT: begin
                    o_rom.req <= ctrl_r[vrd_pkg::CTRL_ROM_EN_BIT];
                    o_rom.addr <= cur_addr;
                    wait_r <= wait_r - 8'h01;
                    if (i_rom_ack && ctrl_r[vrd_pkg::CTRL_ROM_EN_BIT]) begin
                        rom_byte_r <= i_rom_data;
                    end
                    // rom off: contents never reach the bus
                    if (!ctrl_r[vrd_pkg::CTRL_ROM_EN_BIT]) begin
                        rom_byte_r <= vrd_pkg::BYTE_RESET;
                    end
                    if (wait_r == 8'h00) begin
                        st_r <= vrd_pkg::VRD_DONE;
                        o_rom.req <= 1'b0;
                        o_fetch_busy <= 1'b0;
                    end
                end
                vrd_pkg::VRD_DONE: begin
                    st_r <= vrd_pkg::VRD_IDLE;
                end
                default: begin
                    st_r <= vrd_pkg::VRD_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        if (i_req.addr >= vrd_pkg::ADDR_PTR0_HI
            && i_req.addr <= vrd_pkg::ADDR_PTR1_LO) begin
            rdata_nxt = ptr_r[3'(i_req.addr - vrd_pkg::ADDR_PTR0_HI)];
        end
        unique case (i_req.addr)
            vrd_pkg::ADDR_SPEECH_CTRL: rdata_nxt = ctrl_r;
            vrd_pkg::ADDR_DAC_LOW: rdata_nxt = {dac_low_r, 4'h0};
            vrd_pkg::ADDR_DAC_HIGH: rdata_nxt = dac_high_r;
            vrd_pkg::ADDR_LOUDNESS: rdata_nxt = {loud_r, 4'h0};
            vrd_pkg::ADDR_SAMPLE_PORT: begin
                rdata_nxt = rom_byte_r;
                // rom off reads zero at once, before the fetch clears it
                if (!ctrl_r[vrd_pkg::CTRL_ROM_EN_BIT]) begin
                    rdata_nxt = 8'h00;
                end
            end
            default: begin
            end
        endcase
    end

    // read data registered: valid the cycle after i_req.rd
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_req.rd) begin
            o_rdata <= rdata_nxt;
        end
    end

    property p_low_nibble_zero;
        @(posedge i_ref_clk) disable iff (i_rst)
        i_req.rd && i_req.addr == vrd_pkg::ADDR_DAC_LOW
        |=> o_rdata[3:0] == 4'h0;
    endproperty
    a_low_nibble_zero: assert property (p_low_nibble_zero)
        else $error("dac_low low nibble not zero");

    property p_loud_zero;
        @(posedge i_ref_clk) disable iff (i_rst)
        i_req.rd && i_req.addr == vrd_pkg::ADDR_LOUDNESS
        |=> o_rdata[3:0] == 4'h0;
    endproperty
    a_loud_zero: assert property (p_loud_zero)
        else $error("loudness low nibble not zero");

    property p_ctrl_unused;
        @(posedge i_ref_clk) disable iff (i_rst)
        (ctrl_r & ~vrd_pkg::CTRL_USED_MASK) == 8'h00;
    endproperty
    a_ctrl_unused: assert property (p_ctrl_unused)
        else $error("unused control bit set");

    property p_dac_off;
        @(posedge i_ref_clk) disable iff (i_rst)
        !ctrl_r[vrd_pkg::CTRL_DAC_EN_BIT] |=> !o_dac_valid;
    endproperty
    a_dac_off: assert property (p_dac_off)
        else $error("dac valid while off");

    property p_dac_sample;
        @(posedge i_ref_clk) disable iff (i_rst)
        i_req.wr && i_req.addr == vrd_pkg::ADDR_DAC_HIGH
        && ctrl_r[vrd_pkg::CTRL_DAC_EN_BIT] && !(i_req.addr ==
        vrd_pkg::ADDR_SPEECH_CTRL) ##1 ctrl_r[vrd_pkg::CTRL_DAC_EN_BIT]
        |=> o_dac_sample[11:4] == $past(i_req.wdata, 2);
    endproperty
    a_dac_sample: assert property (p_dac_sample)
        else $error("dac sample high byte wrong");

    property p_sleep_keeps;
        @(posedge i_ref_clk) disable iff (i_rst)
        i_sleep && !(i_req.wr && i_req.addr == vrd_pkg::ADDR_SPEECH_CTRL)
        |=> $stable(ctrl_r);
    endproperty
    a_sleep_keeps: assert property (p_sleep_keeps)
        else $error("control changed without write");

    property p_fetch_time;
        @(posedge i_ref_clk) disable iff (i_rst)
        // a newer write takes over the deadline of the older one
        fetch_restart |-> ##[1:201] (st_r == vrd_pkg::VRD_DONE
                                     || fetch_restart);
    endproperty
    a_fetch_time: assert property (p_fetch_time)
        else $error("fetch not done in time");

    property p_rom_off;
        @(posedge i_ref_clk) disable iff (i_rst)
        !ctrl_r[vrd_pkg::CTRL_ROM_EN_BIT] |-> !o_rom.req ##1 1'b1;
    endproperty
    a_rom_off: assert property (p_rom_off)
        else $error("rom request while disabled");

    c_fetch: cover property (@(posedge i_ref_clk) ptr_write ##[1:201]
        st_r == vrd_pkg::VRD_DONE);
    c_dac_on: cover property (@(posedge i_ref_clk) o_dac_valid);
    c_ptr1: cover property (@(posedge i_ref_clk) o_rom.req && ptr_sel);
    c_rom_off: cover property (@(posedge i_ref_clk)
        st_r == vrd_pkg::VRD_WAIT && !ctrl_r[vrd_pkg::CTRL_ROM_EN_BIT]);

    property p_read_port;
        @(posedge i_ref_clk) disable iff (i_rst)
        i_req.rd && i_req.addr == vrd_pkg::ADDR_SAMPLE_PORT
        |=> o_rdata == ($past(ctrl_r[vrd_pkg::CTRL_ROM_EN_BIT])
                        ? $past(rom_byte_r) : 8'h00);
    endproperty
    a_read_port: assert property (p_read_port)
        else $error("sample port read wrong");

    property p_rom_capture;
        @(posedge i_ref_clk) disable iff (i_rst)
        st_r == vrd_pkg::VRD_WAIT && i_rom_ack && !fetch_restart
        && ctrl_r[vrd_pkg::CTRL_ROM_EN_BIT]
        |=> rom_byte_r == $past(i_rom_data);
    endproperty
    a_rom_capture: assert property (p_rom_capture)
        else $error("rom byte not captured");

    property p_ptr1_addr;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_rom.req && ptr_sel |-> o_rom.addr == {ptr_r[3], ptr_r[4], ptr_r[5]};
    endproperty
    a_ptr1_addr: assert property (p_ptr1_addr)
        else $error("pointer 1 address wrong");

    property p_ptr0_addr;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_rom.req && !ptr_sel |-> o_rom.addr == {ptr_r[0], ptr_r[1], ptr_r[2]};
    endproperty
    a_ptr0_addr: assert property (p_ptr0_addr)
        else $error("pointer 0 address wrong");

    property p_dac_on;
        @(posedge i_ref_clk) disable iff (i_rst)
        ctrl_r[vrd_pkg::CTRL_DAC_EN_BIT] |=> o_dac_valid;
    endproperty
    a_dac_on: assert property (p_dac_on)
        else $error("dac not valid while on");

    property p_volume;
        @(posedge i_ref_clk) disable iff (i_rst)
        i_req.wr && i_req.addr == vrd_pkg::ADDR_LOUDNESS
        |=> ##1 o_dac_volume == $past(i_req.wdata[7:5], 2);
    endproperty
    a_volume: assert property (p_volume)
        else $error("volume level wrong");

    property p_xtal_mode;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_xtal_slow_start == $past(ctrl_r[vrd_pkg::CTRL_XTAL_SLOW_BIT]);
    endproperty
    a_xtal_mode: assert property (p_xtal_mode)
        else $error("crystal start mode wrong");
endmodule
`default_nettype wire

// *** tb/vrd_rom_model.sv ***
// behavioural voice rom that answers the block's fetch requests
`default_nettype none
module vrd_rom_model (
    input wire logic i_ref_clk,
    input wire vrd_pkg::vrd_rom_req_t i_rom,
    input wire logic [7:0] i_delay,
    output logic [7:0] o_data,
    output logic o_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wait_r = 8'h00;
    initial begin
        o_data = 8'h00;
        o_ack = 1'b0;
    end
    always @(posedge i_ref_clk) begin
        if (i_rom.req) begin
            wait_r <= wait_r + 8'h01;
            o_ack <= (wait_r >= i_delay);
            // lanes rotated apart so a swapped pointer byte shows up
            o_data <= i_rom.addr[23:16]
                      ^ {i_rom.addr[14:8], i_rom.addr[15]}
                      ^ {i_rom.addr[5:0], i_rom.addr[7:6]}
                      ^ 8'h5A;
        end else begin
            // released bus toggles so a stale byte can never be taken
            wait_r <= 8'h00;
            o_ack <= 1'b0;
            o_data <= ~o_data;
        end
    end
endmodule
`default_nettype wire

// *** tb/vrd_voice_dac_ctrl_bench.sv ***
// self-checking bench of the voice rom and dac control block
`default_nettype none
module vrd_voice_dac_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_sleep = 1'b0;
    vrd_pkg::vrd_req_t i_req = '0;
    logic [7:0] rom_data, rdata, v, hi, lo, ctl, rb;
    logic [7:0] rom_delay = 8'h00;
    logic [7:0] p [0:5];
    logic rom_ack, dac_valid, rom_en, xtal_slow, busy;
    logic [11:0] dac_sample;
    logic [2:0] dac_vol;
    vrd_pkg::vrd_rom_req_t rom;
    int n_mismatch = 0;
    int n_tests = 0;
    int seed = 73219;
    always #10 i_ref_clk = ~i_ref_clk;
    vrd_voice_dac_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_req(i_req), .i_sleep(i_sleep), .i_rom_data(rom_data),
        .i_rom_ack(rom_ack), .o_rdata(rdata), .o_dac_sample(dac_sample),
        .o_dac_volume(dac_vol), .o_dac_valid(dac_valid), .o_rom(rom),
        .o_rom_enable(rom_en), .o_xtal_slow_start(xtal_slow),
        .o_fetch_busy(busy));
    vrd_rom_model i_rom (.i_ref_clk(i_ref_clk), .i_rom(rom),
        .i_delay(rom_delay), .o_data(rom_data), .o_ack(rom_ack));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        i_req.wr = 1'b1;
        i_req.addr = a;
        i_req.wdata = d;
        @(negedge i_ref_clk);
        i_req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_ref_clk);
        i_req.rd = 1'b1;
        i_req.addr = a;
        @(negedge i_ref_clk);
        i_req.rd = 1'b0;
        @(negedge i_ref_clk);
        d = rdata;
    endtask
    function automatic logic [7:0] exp_rom(input logic [23:0] a);
        return a[23:16] ^ {a[14:8], a[15]} ^ {a[5:0], a[7:6]} ^ 8'h5A;
    endfunction
    task automatic print_verdict;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        repeat (3) @(negedge i_ref_clk);
        i_rst = 1'b0;
        rd(vrd_pkg::ADDR_SPEECH_CTRL, v);
        check(v, 8'h00);
        check(xtal_slow, 1'b0);
        rd(8'h3F, v);
        check(v, 8'h00);
        for (int i = 0; i < 16; i++) begin
            ctl = 8'($random(seed));
            hi = 8'($random(seed));
            lo = 8'($random(seed));
            v = 8'($random(seed));
            // sleep follows a random bit so it lands in both states
            i_sleep = ctl[0];
            wr(vrd_pkg::ADDR_SPEECH_CTRL, ctl);
            wr(vrd_pkg::ADDR_DAC_LOW, lo);
            wr(vrd_pkg::ADDR_DAC_HIGH, hi);
            wr(vrd_pkg::ADDR_LOUDNESS, v);
            repeat (2) @(negedge i_ref_clk);
            check(dac_valid, ctl[1]);
            check(dac_sample, ctl[1] ? {hi, lo[7:4]} : 12'h000);
            check(dac_vol, v[7:5]);
            check(rom_en, ctl[2]);
            check(xtal_slow, ctl[7]);
            rd(vrd_pkg::ADDR_LOUDNESS, rb);
            check(rb, v & 8'hF0);
            rd(vrd_pkg::ADDR_DAC_LOW, rb);
            check(rb, lo & 8'hF0);
            rd(vrd_pkg::ADDR_SPEECH_CTRL, rb);
            check(rb, ctl & 8'h96);
            // sample must still stand after the reads
            check(dac_sample, ctl[1] ? {hi, lo[7:4]} : 12'h000);
        end
        for (int i = 0; i < 4; i++) begin
            rom_delay = i[1] ? 8'h96 : 8'h00;
            ctl = {3'b000, i[0], 1'b0, (i != 3), 2'b10};
            wr(vrd_pkg::ADDR_SPEECH_CTRL, ctl);
            for (int k = 0; k < 6; k++) begin
                p[k] = 8'($random(seed));
                wr(vrd_pkg::ADDR_PTR0_HI + 8'(k), p[k]);
            end
            check(busy, 1'b1);
            repeat (210) @(negedge i_ref_clk);
            check(busy, 1'b0);
            rd(vrd_pkg::ADDR_SAMPLE_PORT, v);
            check(v, (i == 3) ? 8'h00 : exp_rom(i[0] ? {p[3], p[4], p[5]}
                : {p[0], p[1], p[2]}));
            rd(vrd_pkg::ADDR_PTR1_LO, v);
            check(v, p[5]);
        end
        print_verdict;
    end
endmodule
`default_nettype wire
